// ===== src/sled_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Two modes come from the mode strap and a third only from configuration.
// - In mode 1 the link indicator is on while link is good, with no blinking.
// - In modes 2 and 3 the link indicator is on with link and blinks on activity.
// - The speed indicator is on at 100 Mb/s and off at 10 Mb/s in every mode.
// - In mode 1 the third indicator is on while transmit or receive is active.
// - In mode 2 the third indicator shows collision.
// - In mode 3 a setting picks duplex or collision, collision by default.
// - Each indicator pin can be an event pin once its indicator is disabled.
// - A reset low for 1 us restores defaults and re-latches the mode strap.
module sled_top import sled_pkg::*; #(
   parameter int unsigned BLINK_CYC = BLINK_HALF_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic mode_strap_pin,
   input sled_status_s status,
   input sled_ctrl_s ctrl,
   input wire logic [2:0] event_out,
   input wire logic [2:0] event_dir_out,
   input wire logic [2:0] pin_in,
   output logic [2:0] event_in,
   output logic [2:0] pin_out,
   output logic [2:0] pin_oe_n,
   output logic [1:0] mode_r
);
   // pin_out[2]=link_indicator_pin/event_io_seven,
   // [1]=speed_indicator_pin/event_io_six,
   // [0]=activity_indicator_pin/event_io_five

   ////////////////////////////////////////////////////////////////////////
   logic strap_s1_r, strap_s2_r;
   logic [2:0] pin_s1_r;
   logic strap_latch_r;
   logic [1:0] strap_wait_r;
   logic [BLINK_CNT_W-1:0] stretch_r;
   logic [BLINK_CNT_W-1:0] blink_cnt_r;
   logic blink_phase_r;
   logic act_now, act_seen;
   logic link_ind, speed_ind, third_ind;
   sled_mode_e mode;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         strap_s1_r <= 1'h0;
         strap_s2_r <= 1'h0;
         pin_s1_r <= 3'h0;
         event_in <= 3'h0;
      end else begin
         strap_s1_r <= mode_strap_pin;
         strap_s2_r <= strap_s1_r;
         pin_s1_r <= pin_in;
         event_in <= pin_s1_r;
      end
   end

   // strap taken only once the synchroniser holds the pin level;
   // its reset value would otherwise always read as mode 1
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         strap_wait_r <= 2'h0;
         strap_latch_r <= 1'h0;
         mode_r <= MODE_STRAP_RST;
      end else if (!strap_latch_r) begin
         if (strap_wait_r == STRAP_SETTLE_CYC) begin
            strap_latch_r <= 1'h1;
            mode_r <= strap_s2_r ? 2'h1 : 2'h0;
         end else begin
            strap_wait_r <= strap_wait_r + 2'h1;
         end
      end
   end

   // mode 3 only reachable through control, overriding the strap
   always_comb begin
      if (ctrl.mode3_en) begin
         mode = SLED_MODE_3;
      end else if (mode_r == 2'h1) begin
         mode = SLED_MODE_2;
      end else begin
         mode = SLED_MODE_1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign act_now = status.tx_active | status.rx_active;
   assign act_seen = act_now | (stretch_r != '0);

   // one-shot stretch so a single short frame still blinks
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         stretch_r <= '0;
      end else if (act_now) begin
         stretch_r <= BLINK_CNT_W'(2 * BLINK_CYC - 1);
      end else if (stretch_r != '0) begin
         stretch_r <= stretch_r - 1'h1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         blink_cnt_r <= '0;
         blink_phase_r <= 1'h0;
      end else if (!act_seen) begin
         blink_cnt_r <= '0;
         blink_phase_r <= 1'h0;
      end else if (blink_cnt_r == BLINK_CNT_W'(BLINK_CYC - 1)) begin
         blink_cnt_r <= '0;
         blink_phase_r <= ~blink_phase_r;
      end else begin
         blink_cnt_r <= blink_cnt_r + 1'h1;
      end
   end

   always_comb begin
      speed_ind = status.speed_100;
      case (mode)
         SLED_MODE_1: begin
            link_ind = status.link_good;
            third_ind = act_seen;
         end
         SLED_MODE_2: begin
            link_ind = status.link_good & ~blink_phase_r;
            third_ind = status.collision;
         end
         default: begin
            link_ind = status.link_good & ~blink_phase_r;
            third_ind = ctrl.duplex_sel ? status.full_duplex
                                        : status.collision;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // indicators active high; disabled indicator hands pin to event logic
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_out <= 3'h0;
         pin_oe_n <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (ctrl.ind_disable[i]) begin
               pin_out[i] <= event_out[i];
               pin_oe_n[i] <= ~event_dir_out[i];
            end else begin
               pin_oe_n[i] <= 1'h0;
               case (i)
                  PIN_LINK: pin_out[i] <= link_ind;
                  PIN_SPEED: pin_out[i] <= speed_ind;
                  default: pin_out[i] <= third_ind;
               endcase
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   sequence s_act_start;
      act_now;
   endsequence
   sequence s_stretch_full;
      stretch_r == BLINK_CNT_W'(2 * BLINK_CYC - 1);
   endsequence

   property p_speed;
      @(posedge clk) disable iff (!nrst)
      !ctrl.ind_disable[PIN_SPEED] |=>
         pin_out[PIN_SPEED] == $past(status.speed_100);
   endproperty
   a_speed: assert property (p_speed)
      else $error("speed indicator wrong");

   property p_stretch;
      @(posedge clk) disable iff (!nrst)
      s_act_start |=> s_stretch_full;
   endproperty
   a_stretch: assert property (p_stretch)
      else $error("activity stretch not loaded");

   property p_mode1_link;
      @(posedge clk) disable iff (!nrst)
      mode == SLED_MODE_1 && !ctrl.ind_disable[PIN_LINK] |=>
         pin_out[PIN_LINK] == $past(status.link_good);
   endproperty
   a_mode1_link: assert property (p_mode1_link)
      else $error("mode 1 link indicator blinks or wrong");

   property p_mode1_act;
      @(posedge clk) disable iff (!nrst)
      mode == SLED_MODE_1 && act_now && !ctrl.ind_disable[PIN_ACT] |=>
         pin_out[PIN_ACT];
   endproperty
   a_mode1_act: assert property (p_mode1_act)
      else $error("mode 1 activity indicator off during activity");

   property p_mode2_col;
      @(posedge clk) disable iff (!nrst)
      mode == SLED_MODE_2 && !ctrl.ind_disable[PIN_ACT] |=>
         pin_out[PIN_ACT] == $past(status.collision);
   endproperty
   a_mode2_col: assert property (p_mode2_col)
      else $error("mode 2 collision indicator wrong");

   property p_mode3_sel;
      @(posedge clk) disable iff (!nrst)
      mode == SLED_MODE_3 && !ctrl.ind_disable[PIN_ACT] |=>
         pin_out[PIN_ACT] == ($past(ctrl.duplex_sel) ?
            $past(status.full_duplex) : $past(status.collision));
   endproperty
   a_mode3_sel: assert property (p_mode3_sel)
      else $error("mode 3 third indicator source wrong");

   property p_link_off;
      @(posedge clk) disable iff (!nrst)
      mode != SLED_MODE_1 && !status.link_good
         && !ctrl.ind_disable[PIN_LINK] |=> !pin_out[PIN_LINK];
   endproperty
   a_link_off: assert property (p_link_off)
      else $error("link indicator on without link");

   property p_event_pin;
      @(posedge clk) disable iff (!nrst)
      ctrl.ind_disable[PIN_LINK] |=>
         pin_out[PIN_LINK] == $past(event_out[PIN_LINK]) &&
         pin_oe_n[PIN_LINK] == !$past(event_dir_out[PIN_LINK]);
   endproperty
   a_event_pin: assert property (p_event_pin)
      else $error("event pin not handed over");

   property p_strap;
      @(posedge clk) disable iff (!nrst)
      $rose(strap_latch_r) |-> mode_r == ($past(strap_s2_r) ? 2'h1 : 2'h0);
   endproperty
   a_strap: assert property (p_strap)
      else $error("mode strap not latched");

   property p_mode3;
      @(posedge clk) disable iff (!nrst)
      ctrl.mode3_en |-> mode == SLED_MODE_3;
   endproperty
   a_mode3: assert property (p_mode3)
      else $error("mode 3 not selected by control");
endmodule

// ===== src/sled_pkg.sv
package sled_pkg;
   // clock rate and timing
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned CLK_PERIOD_NS = 100;
   // least hardware reset pulse, in ns
   localparam int unsigned RESET_MIN_NS = 1000;
   localparam int unsigned RESET_MIN_CYC =
      (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // edges after release before the strap synchroniser holds the pin
   localparam logic [1:0] STRAP_SETTLE_CYC = 2'h2;
   // visible blink half period, in ms
   localparam int unsigned BLINK_HALF_MS = 50;
   localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
   localparam int unsigned BLINK_CNT_W = 20;
   // reset values of the direct control fields
   localparam logic [2:0] IND_DISABLE_RST = 3'h0;
   localparam logic DUPLEX_SEL_RST = 1'h0;
   localparam logic [1:0] MODE_STRAP_RST = 2'h1;
   // pin index order inside the three-bit pin vectors
   localparam int unsigned PIN_ACT = 0;
   localparam int unsigned PIN_SPEED = 1;
   localparam int unsigned PIN_LINK = 2;

   typedef enum logic [1:0] {
      SLED_MODE_1,
      SLED_MODE_2,
      SLED_MODE_3
   } sled_mode_e;

   // status from the transceiver core
   typedef struct packed {
      logic link_good;
      logic speed_100;
      logic full_duplex;
      logic tx_active;
      logic rx_active;
      logic collision;
   } sled_status_s;

   // direct indicator control
   typedef struct packed {
      logic mode3_en;
      logic duplex_sel;
      logic [2:0] ind_disable;
   } sled_ctrl_s;
endpackage

// ===== bench/sled_led_model.sv
`timescale 1ns/100ps
// board side of the three indicator pins: one lamp and a pull-up on each
module sled_led_model (
   input wire logic [2:0] pin_out,
   input wire logic [2:0] pin_oe_n,
   output logic [2:0] pin_in
);
   // a released pin rises to the pull-up, never keeps its last value
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         pin_in[i] = pin_oe_n[i] ? 1'h1 : pin_out[i];
      end
   end
endmodule

// ===== bench/sled_top_tb_top.sv
`timescale 1ns/100ps
module sled_top_tb_top;
   import sled_pkg::*;
   typedef struct {
      logic m3;
      logic ds;
      logic [5:0] s;
      logic [2:0] p;
   } sled_row_s;
   // steady cases only: activity in modes 2 and 3 would blink
   sled_row_s rows [7] = '{
      '{1'h0, 1'h0, 6'h30, 3'h6}, '{1'h0, 1'h0, 6'h0a, 3'h1},
      '{1'h0, 1'h0, 6'h24, 3'h5}, '{1'h1, 1'h0, 6'h29, 3'h5},
      '{1'h1, 1'h1, 6'h28, 3'h5}, '{1'h1, 1'h1, 6'h21, 3'h4},
      '{1'h1, 1'h0, 6'h30, 3'h6}};
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic strap = 1'h0;
   sled_status_s st = '0;
   sled_ctrl_s ct = '0;
   logic [2:0] ev_out = 3'h0;
   logic [2:0] ev_dir = 3'h0;
   logic [2:0] pin_in;
   logic [2:0] event_in;
   logic [2:0] pin_out;
   logic [2:0] pin_oe_n;
   logic [1:0] mode_r;
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int offs = 0;

   always #50 clk = ~clk;

   sled_top #(.BLINK_CYC(4)) u_sled_top (.clk(clk), .nrst(nrst),
      .mode_strap_pin(strap), .status(st), .ctrl(ct), .event_out(ev_out),
      .event_dir_out(ev_dir), .pin_in(pin_in), .event_in(event_in),
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .mode_r(mode_r));
   sled_led_model u_sled_led_model (.pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .pin_in(pin_in));

   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [7:0] seen,
                      input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_of_test();
      if (bad_count == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask

   // whole run is some 170 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         bad_count++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////
   initial begin
      wt(1);
      chk("reset pins", {pin_out, pin_oe_n}, 8'h00);
      chk("reset mode", mode_r, 8'h01);
      // held past the least pulse, not the bare two cycles
      wt(RESET_MIN_CYC);
      nrst = 1'h1;
      wt(3);
      chk("strap low mode", mode_r, 8'h00);
      foreach (rows[i]) begin
         ct.mode3_en = rows[i].m3;
         ct.duplex_sel = rows[i].ds;
         st = rows[i].s;
         wt(12);
         chk("row pins", pin_out, rows[i].p);
      end
      st = 6'h20;
      wt(12);
      st.tx_active = 1'h1;
      wt(1);
      st.tx_active = 1'h0;
      repeat (16) begin
         wt(1);
         offs += !pin_out[PIN_LINK];
      end
      chk("blink off", offs inside {[1:8]}, 8'h01);
      chk("link after blink", pin_out[PIN_LINK], 8'h01);
      ct = '0;
      wt(12);
      st.rx_active = 1'h1;
      wt(1);
      st.rx_active = 1'h0;
      wt(3);
      chk("mode1 stretch", pin_out, 8'h05);
      ct.ind_disable = 3'h5;
      ev_out = 3'h1;
      ev_dir = 3'h4;
      wt(4);
      chk("event pins", {pin_out, pin_oe_n}, 8'h09);
      chk("event in", event_in, 8'h01);
      ct = '0;
      strap = 1'h1;
      nrst = 1'h0;
      wt(RESET_MIN_CYC);
      nrst = 1'h1;
      wt(4);
      chk("strap mode", mode_r, 8'h01);
      st = 6'h21;
      wt(12);
      chk("mode2 collision", pin_out, 8'h05);
      end_of_test();
   end
endmodule
